// >>> hdl/sfq_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sfq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  output logic [AW:0] fillCount
);

  // ****************************************************
  // storage and pointers
  // ****************************************************
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic inReady_r, outValid_r;
  logic wrEn, rdEn;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    wrEn = inValid && inReady_r;
    rdEn = outValid_r && outReady;
    wrPtr_nxt = wrEn ? bump(wrPtr_r) : wrPtr_r;
    rdPtr_nxt = rdEn ? bump(rdPtr_r) : rdPtr_r;
    count_nxt = count_r + (AW+1)'(wrEn) - (AW+1)'(rdEn);
    // output kept in a flop; forward a word landing at the head
    if (wrEn && (wrPtr_r == rdPtr_nxt)) begin
      dout_nxt = inData;
    end else begin
      dout_nxt = mem[rdPtr_nxt];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrPtr_r] <= inData;
    end
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      dout_r <= '0;
      inReady_r <= 1'b0;
      outValid_r <= 1'b0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      dout_r <= dout_nxt;
      inReady_r <= (count_nxt != (AW+1)'(DEPTH));
      outValid_r <= (count_nxt != '0);
    end
  end

  assign inReady = inReady_r;
  assign outValid = outValid_r;
  assign outData = dout_r;
  assign fillCount = count_r;

endmodule : sfq_fifo

`default_nettype wire

// >>> hdl/sfq_flag_irq.sv
// Functional notes
// - while the tx low flag is 1 the tx interrupt request is asserted.
// - while the rx full flag is 1 the rx interrupt request is asserted.
// - the tx interrupt request doubles as a dma refill request.
// - while the rx full flag is 1 a dma drain request is offered.
// - the tx low flag clears when it is read as 1 and then written 0.
// - the rx full flag clears when it is read as 1 and then written 0.
// - if tx occupancy is at or below the tx trigger the flag sets again.
// - if rx occupancy is at or above the rx trigger the flag sets again.
package sfq_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
  localparam int STS_W = 2;
  localparam int STS_TX_BIT = 0;
  localparam int STS_RX_BIT = 1;
  localparam logic [STS_W-1:0] STS_RESET = 2'h0;
  localparam logic [CNT_W-1:0] TX_TRIG_DEF = 6'h08;
  localparam logic [CNT_W-1:0] RX_TRIG_DEF = 6'h01;
endpackage : sfq_pkg

`timescale 1ns/1ps
`default_nettype none

module sfq_flag_irq
  import sfq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // cpu or dma writes into the tx fifo
  input wire logic [DATA_W-1:0] txWrData,
  input wire logic txWrValid,
  output logic txWrReady,
  // serializer drains the tx fifo
  output logic [DATA_W-1:0] txOutData,
  output logic txOutValid,
  input wire logic txOutReady,
  // deserializer fills the rx fifo
  input wire logic [DATA_W-1:0] rxInData,
  input wire logic rxInValid,
  output logic rxInReady,
  // cpu or dma reads the rx fifo
  output logic [DATA_W-1:0] rxRdData,
  output logic rxRdValid,
  input wire logic rxRdReady,
  // trigger levels
  input wire logic [CNT_W-1:0] txTrigger,
  input wire logic [CNT_W-1:0] rxTrigger,
  // status register access
  input wire logic stsRdStrobe,
  input wire logic stsWrStrobe,
  input wire logic [STS_W-1:0] stsWrData,
  output logic [STS_W-1:0] statusReg,
  output logic [CNT_W-1:0] txFillLevel,
  output logic [CNT_W-1:0] rxFillLevel,
  // requests
  output logic txRequestIrq,
  output logic rxRequestIrq,
  output logic txDmaReq,
  output logic rxDmaReq
);

  // ****************************************************
  // fifos
  // ****************************************************
  logic [CNT_W-1:0] txCount;
  logic [CNT_W-1:0] rxCount;

  // tx: cpu or dma fills it, the serializer drains it
  sfq_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inData(txWrData),
    .inValid(txWrValid),
    .inReady(txWrReady),
    .outData(txOutData),
    .outValid(txOutValid),
    .outReady(txOutReady),
    .fillCount(txCount)
  );

  // rx: the deserializer fills it, cpu or dma drains it
  sfq_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inData(rxInData),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .outData(rxRdData),
    .outValid(rxRdValid),
    .outReady(rxRdReady),
    .fillCount(rxCount)
  );

  // ****************************************************
  // fill levels
  // ****************************************************
  // the counters are flops, so these outputs stay registered
  assign txFillLevel = txCount;
  assign rxFillLevel = rxCount;

  // ****************************************************
  // flags
  // ****************************************************
  logic [STS_W-1:0] flag_r, flag_nxt;
  logic [STS_W-1:0] armed_r, armed_nxt;
  wire logic [STS_W-1:0] setCond;
  wire logic [STS_W-1:0] clrCond;

  // set condition of one flag: tx wants a low fill, rx a high one
  function automatic logic levelMet(
    input int bitIdx,
    input logic [CNT_W-1:0] txFill,
    input logic [CNT_W-1:0] rxFill,
    input logic [CNT_W-1:0] txTrig,
    input logic [CNT_W-1:0] rxTrig
  );
    levelMet = 1'b0;
    // rx sets on reaching the trigger, which also covers above it
    case (bitIdx)
      STS_TX_BIT: levelMet = (txFill <= txTrig);
      STS_RX_BIT: levelMet = (rxFill >= rxTrig);
      default: levelMet = 1'b0;
    endcase
  endfunction : levelMet

  // clear hit: flag armed by an earlier read and now written 0
  // a bit written 1 is left alone
  function automatic logic clearHit(
    input logic wrStrobe,
    input logic armed,
    input logic wrBit
  );
    clearHit = wrStrobe && armed && !wrBit;
  endfunction : clearHit

  // one slice per status bit
  for (genvar gb = 0; gb < STS_W; gb++) begin : gFlagBit
    assign setCond[gb] =
      levelMet(gb, txCount, rxCount, txTrigger, rxTrigger);
    assign clrCond[gb] = clearHit(stsWrStrobe, armed_r[gb], stsWrData[gb]);
  end : gFlagBit

  always_comb begin
    // armed only by a read that saw the flag at 1
    armed_nxt = armed_r;
    if (stsRdStrobe) begin
      armed_nxt = armed_r | flag_r;
    end
    // any write disarms both bits, so each clear needs a fresh read
    if (stsWrStrobe) begin
      armed_nxt = '0;
    end
    // set wins, so an event in the clear cycle survives
    flag_nxt = (flag_r & ~clrCond) | setCond;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= STS_RESET;
      armed_r <= STS_RESET;
    end else begin
      flag_r <= flag_nxt;
      armed_r <= armed_nxt;
    end
  end

  // ****************************************************
  // requests
  // ****************************************************
  // one flop per request so each output comes from a register
  logic txIrq_r, rxIrq_r, txDma_r, rxDma_r;
  logic txIrq_nxt, rxIrq_nxt, txDma_nxt, rxDma_nxt;

  // taken from the next flag so requests move with statusReg
  always_comb begin
    txIrq_nxt = flag_nxt[STS_TX_BIT];
    rxIrq_nxt = flag_nxt[STS_RX_BIT];
    txDma_nxt = flag_nxt[STS_TX_BIT];
    rxDma_nxt = flag_nxt[STS_RX_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txIrq_r <= STS_RESET[STS_TX_BIT];
      rxIrq_r <= STS_RESET[STS_RX_BIT];
      txDma_r <= STS_RESET[STS_TX_BIT];
      rxDma_r <= STS_RESET[STS_RX_BIT];
    end else begin
      txIrq_r <= txIrq_nxt;
      rxIrq_r <= rxIrq_nxt;
      txDma_r <= txDma_nxt;
      rxDma_r <= rxDma_nxt;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign statusReg = flag_r;
  assign txRequestIrq = txIrq_r;
  assign rxRequestIrq = rxIrq_r;
  assign txDmaReq = txDma_r;
  assign rxDmaReq = rxDma_r;

endmodule : sfq_flag_irq

`default_nettype wire

// >>> bench/sfq_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// dma side
// ****
module sfq_dma_model (
  input wire logic ref_clk,
  input wire logic stall,
  output logic txOutReady = 1'b0,
  output logic rxRdReady = 1'b0
);
  always @(negedge ref_clk) begin
    txOutReady <= !stall && ($urandom % 2);
    rxRdReady <= !stall && ($urandom % 3 != 0);
  end
endmodule : sfq_dma_model
`default_nettype wire

// >>> bench/sfq_flag_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// flag checks
// ****
module sfq_flag_irq_checker
  import sfq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stsRdStrobe,
  input wire logic stsWrStrobe,
  input wire logic [STS_W-1:0] stsWrData,
  input wire logic [STS_W-1:0] statusReg,
  input wire logic [CNT_W-1:0] txFillLevel,
  input wire logic [CNT_W-1:0] rxFillLevel,
  input wire logic [CNT_W-1:0] txTrigger,
  input wire logic [CNT_W-1:0] rxTrigger,
  input wire logic txRequestIrq,
  input wire logic rxRequestIrq,
  input wire logic txDmaReq,
  input wire logic rxDmaReq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence clr(f, d); stsRdStrobe && f ##1 stsWrStrobe && !d; endsequence
  tx_irq_a: assert property (txRequestIrq == statusReg[0])
    else $error("tx irq");
  rx_irq_a: assert property (rxRequestIrq == statusReg[1])
    else $error("rx irq");
  tx_dma_a: assert property (txDmaReq == txRequestIrq)
    else $error("tx dma");
  rx_dma_a: assert property (rxDmaReq == statusReg[1])
    else $error("rx dma");
  tx_clr_a: assert property (clr(statusReg[0], stsWrData[0])
    ##0 txFillLevel > txTrigger |=> !statusReg[0]) else $error("tx clr");
  rx_clr_a: assert property (clr(statusReg[1], stsWrData[1])
    ##0 rxFillLevel < rxTrigger |=> !statusReg[1]) else $error("rx clr");
  tx_set_a: assert property (
    txFillLevel <= txTrigger |=> statusReg[0]) else $error("tx set");
  rx_set_a: assert property (
    rxFillLevel >= rxTrigger |=> statusReg[1]) else $error("rx set");
endmodule : sfq_flag_irq_checker
`default_nettype wire

// >>> bench/sfq_flag_irq_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module sfq_flag_irq_test import sfq_pkg::*;;
  logic ref_clk = 0, rst = 1, stall = 1, txWrValid = 0, rxInValid = 0;
  logic stsRdStrobe = 0, stsWrStrobe = 0, txOutReady, rxRdReady;
  logic txWrReady, rxInReady, txOutValid, rxRdValid, txRequestIrq;
  logic rxRequestIrq, txDmaReq, rxDmaReq;
  logic [STS_W-1:0] stsWrData = 2'h3, statusReg;
  logic [DATA_W-1:0] txWrData = 0, rxInData = 0, txOutData, rxRdData;
  logic [CNT_W-1:0] txTrigger = TX_TRIG_DEF, rxTrigger = RX_TRIG_DEF;
  logic [CNT_W-1:0] txFillLevel, rxFillLevel;
  logic [DATA_W-1:0] txQ[$], rxQ[$];
  int errCount = 0, samplesChecked = 0;
  sfq_flag_irq uut (.ref_clk, .rst, .txWrData, .txWrValid, .txWrReady,
    .txOutData, .txOutValid, .txOutReady, .rxInData, .rxInValid,
    .rxInReady, .rxRdData, .rxRdValid, .rxRdReady, .txTrigger, .rxTrigger,
    .stsRdStrobe, .stsWrStrobe, .stsWrData, .statusReg, .txFillLevel,
    .rxFillLevel, .txRequestIrq, .rxRequestIrq, .txDmaReq, .rxDmaReq);
  sfq_dma_model dma (.ref_clk, .stall, .txOutReady, .rxRdReady);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic finishTest;
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finishTest
  // overfills on purpose, refused words are not noted
  task automatic fill(input int n, input bit rx);
    repeat (n) begin
      @(negedge ref_clk);
      txWrValid = !rx;
      rxInValid = rx;
      txWrData = 8'($urandom);
      rxInData = 8'($urandom);
    end
    @(negedge ref_clk);
    txWrValid = 0;
    rxInValid = 0;
  endtask : fill
  task automatic clr(input int b);
    @(negedge ref_clk);
    stsRdStrobe = 1;
    @(negedge ref_clk);
    stsRdStrobe = 0;
    stsWrStrobe = 1;
    stsWrData = b ? 2'h1 : 2'h2;
    @(negedge ref_clk);
    stsWrStrobe = 0;
  endtask : clr
  always @(posedge ref_clk) begin
    if (txWrValid && txWrReady) txQ.push_back(txWrData);
    if (rxInValid && rxInReady) rxQ.push_back(rxInData);
  end
  always @(posedge ref_clk) begin
    if (txOutValid && txOutReady) check(txOutData, txQ.pop_front());
    if (rxRdValid && rxRdReady) check(rxRdData, rxQ.pop_front());
  end
  initial begin
    #20us;
    errCount++;
    finishTest;
  end
  initial begin
    void'($urandom(32'h9f45));
    rxTrigger = 6'(2 + $urandom % 8);
    repeat (4) @(negedge ref_clk);
    rst = 0;
    repeat (2) @(negedge ref_clk);
    check(8'(statusReg), 8'h01);
    check(8'({txRequestIrq, txDmaReq}), 8'h03);
    check(8'({rxRequestIrq, rxDmaReq}), 8'h00);
    clr(0);
    check(8'(statusReg), 8'h01);
    fill(34, 0);
    check(8'(txFillLevel), 8'h20);
    check(8'(txWrReady), 8'h00);
    clr(0);
    check(8'(statusReg), 8'h00);
    $display("tx clear done");
    fill(20, 1);
    check(8'(statusReg), 8'h02);
    check(8'({rxRequestIrq, rxDmaReq}), 8'h03);
    check(8'({txRequestIrq, txDmaReq}), 8'h00);
    clr(1);
    check(8'(statusReg), 8'h02);
    @(posedge ref_clk);
    stall = 0;
    for (int i = 0; i < 300 && (txFillLevel | rxFillLevel) != 0; i++)
      @(negedge ref_clk);
    @(posedge ref_clk);
    stall = 1;
    clr(1);
    check(8'(statusReg), 8'h01);
    check(8'(rxFillLevel), 8'h00);
    check(8'(txQ.size() + rxQ.size()), 8'h00);
    $display("rx clear done");
    finishTest;
  end
endmodule : sfq_flag_irq_test
bind sfq_flag_irq sfq_flag_irq_checker chk (.ref_clk, .rst, .stsRdStrobe,
  .stsWrStrobe, .stsWrData, .statusReg, .txFillLevel, .rxFillLevel,
  .txTrigger, .rxTrigger, .txRequestIrq, .rxRequestIrq, .txDmaReq,
  .rxDmaReq);
`default_nettype wire
